// *** verification/dual_slope_and_six_output_pwm_tb_top.sv ***
// Self-checking bench: register access, duty of each output mode, irq, pins.
// Assumes TICK_DIV of 1, so the timer steps every clock.
`timescale 1ns/1ps

module dual_slope_and_six_output_pwm_tb_top;
  import pwm_pkg::*;
  typedef struct packed {
    logic [15:0]     ctl;
    logic [9:0]      cmp;
    logic [5:0]      ovr;
    logic [5:0][7:0] e;
  } row_t;
  logic ref_clk = 1'b0, nrst = 1'b0, clr = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  logic [5:0] pin, oe;
  logic [5:0][7:0] cnt;
  int failures = 0, n_checks = 0;
  // Pins 5..0 on-time out of 80 clocks; top is 4 throughout
  row_t rows[9] = '{
    '{16'h0209, 10'h1, 6'h00, 48'h000000000014}, '{16'h0309, 10'h1, 6'h00, 48'h00000000003C},
    '{16'h0109, 10'h2, 6'h00, 48'h00000000321E}, '{16'h0209, 10'h0, 6'h00, 48'h000000000000},
    '{16'h0209, 10'h4, 6'h00, 48'h000000000050}, '{16'h0309, 10'h0, 6'h00, 48'h000000000050},
    '{16'h2A11, 10'h2, 6'h3F, 48'h303030303030}, '{16'h2A19, 10'h1, 6'h15, 48'h001400140014},
    '{16'h0A19, 10'h1, 6'h3F, 48'h000014141414}};

  // Dual-slope, six-output single-slope and six-output dual-slope
  logic [31:0] ovf_ctl[3] = '{32'h0209, 32'h2A11, 32'h2A19};

  always #25 ref_clk = ~ref_clk;

  dual_slope_six_pwm #(.TICK_DIV(1)) DUT (.ref_clk(ref_clk), .nrst(nrst), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .compare_output_pin(pin),
    .compare_output_pin_oe(oe), .irq(irq));
  power_stage_model u_stage (.ref_clk(ref_clk), .clr(clr), .gate(pin), .gate_oe(oe),
    .high_cnt(cnt));

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge ref_clk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    // Ready is raised only once the response is seen, so the slave must hold it
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 50) begin failures++; end_of_test(); end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 50) begin failures++; end_of_test(); end
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(OFS_TOP, d, r);
    chk("top reset", 32'h3FF, d);
    $display("reset test done");
    wr(OFS_TOP, 32'h4, r);
    wr(OFS_DIR, 32'h3F, r);
    // ****************************************************************
    // Duty of every output mode over 80 clocks
    // ****************************************************************
    foreach (rows[k]) begin
      wr(OFS_CMP_A, 32'(rows[k].cmp), r);
      wr(OFS_OVR, 32'(rows[k].ovr), r);
      wr(OFS_CTRL, 32'(rows[k].ctl), r);
      repeat (24) @(posedge ref_clk);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      repeat (80) @(posedge ref_clk);
      #1;
      for (int p = 0; p < 2; p++) begin
        chk("duty", 32'(rows[k].e[p]), 32'(cnt[p]));
      end
      for (int p = 2; p < 6; p++) begin
        chk("duty", 32'(rows[k].e[p]), 32'(cnt[p]));
      end
      $display("duty row %0d done", k);
    end
    // ****************************************************************
    // Overflow interrupt: raise, mask, clear
    // ****************************************************************
    // CTRL cleared first, which sets no flag, so the flag can only come back from the mode under test
    wr(OFS_MASK, 32'h1, r);
    foreach (ovf_ctl[j]) begin
      wr(OFS_CTRL, 32'h0, r);
      wr(OFS_STATUS, 32'h1, r);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(OFS_CTRL, ovf_ctl[j], r);
      repeat (12) @(posedge ref_clk);
      chk("irq raised", 32'h1, 32'(irq));
    end
    wr(OFS_MASK, 32'h0, r);
    @(posedge ref_clk);
    chk("irq masked", 32'h0, 32'(irq));
    wr(OFS_CTRL, 32'h0, r);
    wr(OFS_STATUS, 32'h1, r);
    rd(OFS_STATUS, d, r);
    chk("status cleared", 32'h0, d);
    $display("irq test done");
    // ****************************************************************
    // Direction gates the compare output; port value elsewhere
    // ****************************************************************
    wr(OFS_CMP_A, 32'h4, r);
    wr(OFS_CTRL, 32'h0209, r);
    wr(OFS_PORT, 32'h2A, r);
    wr(OFS_DIR, 32'h0F, r);
    repeat (20) @(posedge ref_clk);
    chk("pins driven", 32'h2B, 32'(pin));
    chk("drive enables", 32'h0F, 32'(oe));
    wr(OFS_DIR, 32'h0E, r);
    repeat (4) @(posedge ref_clk);
    chk("pins port", 32'h2A, 32'(pin));
    $display("direction test done");
    // ****************************************************************
    // Override bits reach the pins without waiting for the counter
    // ****************************************************************
    wr(OFS_PORT, 32'h0, r);
    wr(OFS_DIR, 32'h3F, r);
    wr(OFS_OVR, 32'h3F, r);
    wr(OFS_CTRL, 32'h2A19, r);
    repeat (4) @(posedge ref_clk);
    chk("override all", 32'h3F, 32'(pin));
    wr(OFS_OVR, 32'h01, r);
    chk("override next clock", 32'h01, 32'(pin));
    $display("override test done");
    // ****************************************************************
    // Register fields and an unmapped address
    // ****************************************************************
    wr(OFS_CTRL, 32'hFFFF, r);
    rd(OFS_CTRL, d, r);
    chk("ctrl fields", 32'h3F1F, d);
    wr(8'h2C, 32'h1, r);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
    rd(8'h2C, d, r);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    $display("register test done");
    end_of_test();
  end
endmodule

// *** verification/power_stage_model.sv ***
// Behavioural power stage on the compare pins: counts on-time per gate.
// Assumes the bench pulses clr for one clock before each measurement.
`timescale 1ns/1ps

module power_stage_model
  import pwm_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            clr,
  input wire logic [NPIN-1:0] gate,
  input wire logic [NPIN-1:0] gate_oe,
  output logic [NPIN-1:0][7:0] high_cnt
);
  // Gate inputs are pulled down, so a released pin counts as off
  always @(posedge ref_clk) begin
    for (int i = 0; i < NPIN; i++) begin
      if (clr) high_cnt[i] <= 8'h00;
      else high_cnt[i] <= high_cnt[i] + 8'(gate[i] & gate_oe[i]);
    end
  end
endmodule

// *** verification/pwm_chk.sv ***
// Port-level assertions for the dual-slope / six-output PWM block.
// Assumes it is bound into every instance of the design's top module.
`timescale 1ns/1ps

module pwm_chk
  import pwm_pkg::*;
#(
  parameter int TICK_DIV = 1
) (
  input wire logic            ref_clk,
  input wire logic            nrst,
  input wire logic            awvalid,
  input wire logic            awready,
  input wire logic            wvalid,
  input wire logic            wready,
  input wire logic [1:0]      bresp,
  input wire logic            bvalid,
  input wire logic            bready,
  input wire logic            arvalid,
  input wire logic            arready,
  input wire logic [31:0]     rdata,
  input wire logic [1:0]      rresp,
  input wire logic            rvalid,
  input wire logic            rready,
  input wire logic [NPIN-1:0] compare_output_pin,
  input wire logic [NPIN-1:0] compare_output_pin_oe,
  input wire logic            irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped or changed before bready");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read data dropped or changed before rready");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after address and data");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one cycle after address");
  a_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while a response is pending");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read accepted while read data is pending");

  // ****************************************************************
  // Reset, pins and coverage
  // ****************************************************************
  // Checked without the default disable so the reset state itself is seen
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !irq && !bvalid
    && !rvalid && compare_output_pin_oe == 6'h00)
    else $error("outputs not idle after reset");
  // Drive enables only move in the clock a register write lands and bvalid rises
  a_oe_after_write: assert property ($changed(compare_output_pin_oe) |-> bvalid)
    else $error("pin drive enable changed without a write");

  c_irq: cover property ($rose(irq));
  c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
  c_pin_rise: cover property ($rose(compare_output_pin[0]));
  c_read: cover property (rvalid && rready);
endmodule

bind dual_slope_six_pwm pwm_chk #(.TICK_DIV(TICK_DIV)) u_chk (.*);

// *** verilog/dual_slope_six_pwm.sv ***
// Dual-slope phase/frequency-correct PWM and six-output commutation PWM,
// with an AXI4-Lite register slave and a masked overflow interrupt.
// Assumes one system clock; the timer runs on an enable from a divider.
//
// Summary of operation
// - Both enable and select-low give dual-slope PWM
// - Dual-slope counts zero to top and back
// - Top held one tick, then direction reverses
// - Non-inverting clears on up match, sets down
// - Complementary clears on match, sets at zero
// - Dual-slope overflow flag set at zero
// - Mode two noninverted, three inverted, one complementary
// - Compare drives pin only if mode and direction
// - Compare zero low, maximum high, inverted opposite
// - Channel A enable plus select-high: six-output mode
// - Channel A waveform drives all six pins
// - Six-output single-slope wraps top to zero
// - Counter clears tick after matching top
// - Single-slope six-output overflow set at top
// - Six-output dual-slope: up match, back down
// - Six-output dual-slope overflow set at zero
// - Override bit selects compare or port value
// - Mode zero disconnects pair; else wave AND enable
`timescale 1ns/1ps

module dual_slope_six_pwm
  import pwm_pkg::*;
#(
  parameter int TICK_DIV = 1
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [NPIN-1:0]        compare_output_pin,
  output logic [NPIN-1:0]        compare_output_pin_oe,
  output logic                   irq
);

  // ******************************************************************
  // State
  // ******************************************************************
  st_t s_reg;
  st_t s_next;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [32:0] read_word(input st_t s,
                                            input logic [ADDR_W-1:0] a);
    logic [31:0] d;
    logic        hit;
    d   = '0;
    hit = 1'b1;
    case (a)
      OFS_CTRL:   d[CTRL_W-1:0] = s.ctl;
      OFS_TOP:    d[CNT_W-1:0]  = s.top_compare_value;
      OFS_CMP_A:  d[CNT_W-1:0]  = s.channel_compare_value[0];
      OFS_CMP_B:  d[CNT_W-1:0]  = s.channel_compare_value[1];
      OFS_CMP_D:  d[CNT_W-1:0]  = s.channel_compare_value[2];
      OFS_OVR:    d[NPIN-1:0]   = s.pin_override_enables;
      OFS_PORT:   d[NPIN-1:0]   = s.port_value;
      OFS_DIR:    d[NPIN-1:0]   = s.pin_direction;
      OFS_STATUS: d[POS_OVF_FLAG] = s.overflow_flag;
      OFS_MASK:   d[POS_OVF_FLAG] = s.overflow_mask;
      OFS_COUNT: begin
        d[CNT_W-1:0]   = s.timer_count;
        d[POS_COUNT_UP] = s.count_up;
      end
      default:    hit = 1'b0;
    endcase
    return {hit, d};
  endfunction

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    logic                 tick;
    logic                 six;
    logic                 dual;
    logic [NCH-1:0]       pfc;
    logic [CNT_W-1:0]     cnt_nx;
    logic                 up_nx;
    logic                 wrap;
    logic                 bottom;
    logic                 ov_set;
    logic                 ov_clr;
    logic [CNT_W-1:0]     cv;
    logic [1:0]           m;
    logic                 inv;
    logic                 hit;
    logic                 w;
    logic                 wa;
    logic                 conn;
    logic [32:0]          rd;
    logic [31:0]          mw;
    tick   = 1'b0;
    six    = 1'b0;
    dual   = 1'b0;
    pfc    = '0;
    cnt_nx = '0;
    up_nx  = 1'b0;
    wrap   = 1'b0;
    bottom = 1'b0;
    ov_set = 1'b0;
    ov_clr = 1'b0;
    cv     = '0;
    m      = '0;
    inv    = 1'b0;
    hit    = 1'b0;
    w      = 1'b0;
    wa     = 1'b0;
    conn   = 1'b0;
    rd     = '0;
    mw     = '0;
    s_next = s_reg;

    // Timer clock enable
    tick = (s_reg.div >= DIV_LAST);
    s_next.div = tick ? '0 : s_reg.div + 1'b1;

    // Mode decode
    six = s_reg.ctl.channel_pwm_enable[0] & s_reg.ctl.waveform_select_high;
    for (int c = 0; c < NCH; c++) begin
      pfc[c] = s_reg.ctl.channel_pwm_enable[c] & s_reg.ctl.waveform_select_low
               & ~six;
    end
    dual = s_reg.ctl.waveform_select_low & (six | (|pfc));

    // Counter
    cnt_nx = s_reg.timer_count;
    up_nx  = s_reg.count_up;
    if (tick) begin
      if (dual) begin
        if (s_reg.count_up) begin
          if (s_reg.timer_count >= s_reg.top_compare_value) begin
            // Top was shown for this one tick; now turn round
            cnt_nx = (s_reg.top_compare_value == '0) ? '0
                     : s_reg.top_compare_value - 1'b1;
            up_nx  = 1'b0;
          end else begin
            cnt_nx = s_reg.timer_count + 1'b1;
          end
        end else begin
          if (s_reg.timer_count == '0) begin
            cnt_nx = (s_reg.top_compare_value == '0) ? '0 : CNT_W'(1);
            up_nx  = 1'b1;
          end else begin
            cnt_nx = s_reg.timer_count - 1'b1;
          end
        end
      end else begin
        // Clear on the tick after the one that matched top
        cnt_nx = (s_reg.timer_count >= s_reg.top_compare_value) ? '0
                 : s_reg.timer_count + 1'b1;
        up_nx  = 1'b1;
      end
    end
    s_next.timer_count = cnt_nx;
    s_next.count_up    = up_nx;
    wrap   = tick & ~dual & (s_reg.timer_count >= s_reg.top_compare_value);
    bottom = tick & dual & (cnt_nx == '0);
    if (dual) begin
      ov_set = bottom;
    end else begin
      ov_set = tick & six & (cnt_nx == s_reg.top_compare_value);
    end

    // Waveform per channel; in six-output mode all use channel A compare
    for (int c = 0; c < NCH; c++) begin
      cv  = six ? s_reg.channel_compare_value[0]
                : s_reg.channel_compare_value[c];
      m   = s_reg.ctl.output_mode[c];
      inv = (m == COM_INV);
      hit = tick & (s_reg.timer_count == cv);
      w   = s_reg.waveform_output[c];
      if (dual) begin
        if (m == COM_COMPL) begin
          if (bottom) begin
            w = 1'b1;
          end
          if (hit) begin
            w = 1'b0;
          end
        end else if (cv == '0) begin
          w = inv;
        end else if (cv >= s_reg.top_compare_value) begin
          w = ~inv;
        end else if (hit) begin
          w = s_reg.count_up ? inv : ~inv;
        end
      end else begin
        if (wrap) begin
          w = ~inv;
        end
        if (hit) begin
          w = inv;
        end
      end
      s_next.waveform_output[c] = w;
    end

    // Pin multiplexing from registered waveform and settings
    wa = s_reg.waveform_output[0];
    for (int c = 0; c < NCH; c++) begin
      m = s_reg.ctl.output_mode[c];
      for (int k = 0; k < 2; k++) begin
        if (six) begin
          // Override bits act on the next clock, not on a counter event
          conn = (m != COM_OFF) & s_reg.pin_override_enables[2*c+k];
          w    = wa & s_reg.pin_override_enables[2*c+k];
        end else begin
          conn = pfc[c] & (k == 0 ? (m != COM_OFF) : (m == COM_COMPL));
          w    = (k == 0) ? s_reg.waveform_output[c] : ~s_reg.waveform_output[c];
        end
        conn = conn & s_reg.pin_direction[2*c+k];
        s_next.pin[2*c+k] = conn ? w : s_reg.port_value[2*c+k];
      end
    end

    // AXI4-Lite write channel: address and data in either order
    if (awvalid && !s_reg.aw_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = awaddr;
    end
    if (wvalid && !s_reg.w_got && !s_reg.bvalid) begin
      s_next.w_got = 1'b1;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      rd = read_word(s_reg, s_reg.awaddr);
      mw = merge(rd[31:0], s_reg.wdata, s_reg.wstrb);
      s_next.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      case (s_reg.awaddr)
        OFS_CTRL: begin
          s_next.ctl     = ctl_t'(mw[CTRL_W-1:0]);
          s_next.ctl.pad = '0;
        end
        OFS_TOP:    s_next.top_compare_value = mw[CNT_W-1:0];
        OFS_CMP_A:  s_next.channel_compare_value[0] = mw[CNT_W-1:0];
        OFS_CMP_B:  s_next.channel_compare_value[1] = mw[CNT_W-1:0];
        OFS_CMP_D:  s_next.channel_compare_value[2] = mw[CNT_W-1:0];
        OFS_OVR:    s_next.pin_override_enables = mw[NPIN-1:0];
        OFS_PORT:   s_next.port_value = mw[NPIN-1:0];
        OFS_DIR:    s_next.pin_direction = mw[NPIN-1:0];
        OFS_STATUS: ov_clr = s_reg.wdata[POS_OVF_FLAG] & s_reg.wstrb[0];
        OFS_MASK:   s_next.overflow_mask = mw[POS_OVF_FLAG];
        default:    ov_clr = 1'b0;
      endcase
    end
    // A new overflow in the clearing cycle is kept
    s_next.overflow_flag = (s_reg.overflow_flag & ~ov_clr) | ov_set;

    // AXI4-Lite read channel
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && !s_reg.rvalid) begin
      rd = read_word(s_reg, araddr);
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd[31:0];
      s_next.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_reg                   <= '0;
      s_reg.top_compare_value <= TOP_RST;
      s_reg.channel_compare_value <= {NCH{CMP_RST}};
      s_reg.count_up          <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign awready = !s_reg.aw_got && !s_reg.bvalid;
  assign wready  = !s_reg.w_got && !s_reg.bvalid;
  assign bvalid  = s_reg.bvalid;
  assign bresp   = s_reg.bresp;
  assign arready = !s_reg.rvalid;
  assign rvalid  = s_reg.rvalid;
  assign rdata   = s_reg.rdata;
  assign rresp   = s_reg.rresp;
  assign compare_output_pin    = s_reg.pin;
  assign compare_output_pin_oe = s_reg.pin_direction;
  assign irq = s_reg.overflow_flag & s_reg.overflow_mask;

endmodule

// *** verilog/pwm_pkg.sv ***
// Constants, register map and state layout of the dual-slope / six-output PWM.
// Assumes a 32-bit AXI4-Lite master and a single 20 MHz system clock.
package pwm_pkg;

  // ******************************************************************
  // Widths and clock
  // ******************************************************************
  localparam int CNT_W    = 10;
  localparam int DIV_W    = 16;
  localparam int ADDR_W   = 8;
  localparam int NCH      = 3;
  localparam int NPIN     = 6;
  localparam int CTRL_W   = 14;
  localparam int CLK_HZ   = 20_000_000;

  // ******************************************************************
  // Register byte offsets
  // ******************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TOP    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP_A  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMP_B  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CMP_D  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OVR    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PORT   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_DIR    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h28;

  // ******************************************************************
  // Field positions and reset values
  // ******************************************************************
  localparam int POS_OVF_FLAG = 0;
  localparam int POS_COUNT_UP = 16;
  localparam logic [CNT_W-1:0] TOP_RST = 10'h3FF;
  localparam logic [CNT_W-1:0] CMP_RST = 10'h000;

  // Compare output mode encodings
  localparam logic [1:0] COM_OFF   = 2'h0;
  localparam logic [1:0] COM_COMPL = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV   = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef struct packed {
    logic [NCH-1:0][1:0] output_mode;
    logic [2:0]          pad;
    logic                waveform_select_high;
    logic                waveform_select_low;
    logic [NCH-1:0]      channel_pwm_enable;
  } ctl_t;

  typedef struct packed {
    ctl_t                      ctl;
    logic [CNT_W-1:0]          top_compare_value;
    logic [NCH-1:0][CNT_W-1:0] channel_compare_value;
    logic [NPIN-1:0]           pin_override_enables;
    logic [NPIN-1:0]           port_value;
    logic [NPIN-1:0]           pin_direction;
    logic                      overflow_flag;
    logic                      overflow_mask;
    logic [CNT_W-1:0]          timer_count;
    logic                      count_up;
    logic [NCH-1:0]            waveform_output;
    logic [DIV_W-1:0]          div;
    logic [NPIN-1:0]           pin;
    logic                      aw_got;
    logic                      w_got;
    logic [ADDR_W-1:0]         awaddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } st_t;

endpackage
